// ==== ifq_defines.vh ====
// Register offsets, field positions and fixed values of the image format query bank.
`ifndef IFQ_DEFINES_VH
`define IFQ_DEFINES_VH

`define IFQ_ADDR_W 12
`define IFQ_OFF_CODING_CAPS 12'h014
`define IFQ_OFF_PIXEL_COUNT 12'h034
`define IFQ_OFF_BYTES_UPPER 12'h038
`define IFQ_OFF_BYTES_LOWER 12'h03C
`define IFQ_OFF_PKT_LIMITS 12'h040
`define IFQ_OFF_PKT_SIZE 12'h044
`define IFQ_OFF_PKT_PER_FRAME 12'h048

// Bit 0 of a quadlet is its most significant bit, so the first half sits high.
`define IFQ_FIRST_HALF 31:16
`define IFQ_SECOND_HALF 15:0

`define IFQ_PKT_UNIT 16'h0004
`define IFQ_PKT_MAX 16'h1000
`define IFQ_PKT_SIZE_RST 16'h1000
`define IFQ_PPF_LIMIT 16'h0FFF
`define IFQ_CODING_CAPS_RST 11'h001
`define IFQ_DIV_STEPS 6'h28

`endif

// ==== ifq_regs.v ====
// Image format query registers, packet size control and packetising FIFO.
`timescale 1ns/100ps
`include "ifq_defines.vh"

////////////////////////////////////////////////////////////////////////////////

module ifq_fifo #(
	parameter W = 32,
	parameter DEPTH = 32,
	parameter AW = 5
) (
	input wire clk_in, // Clock.
	input wire rstn_in, // Synchronised reset, active low.
	input wire [W-1:0] in_data_in, // Write data.
	input wire in_valid_in, // Write data valid.
	output wire in_ready_out, // Space available.
	output wire [W-1:0] out_data_out, // Head entry.
	output wire out_valid_out, // Head entry valid.
	input wire out_ready_in // Drain side accepts.
);
	reg [W-1:0] mem_q [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_q;
	reg [AW-1:0] rd_ptr_q;
	reg [AW:0] cnt_q;
	reg [AW:0] cnt_d;
	reg ready_q;
	wire push;
	wire pop;
	genvar i;

	assign push = in_valid_in & ready_q;
	assign pop = out_ready_in & (cnt_q != {(AW+1){1'b0}});
	assign in_ready_out = ready_q;
	assign out_valid_out = (cnt_q != {(AW+1){1'b0}});
	assign out_data_out = mem_q[rd_ptr_q];

	always @* begin
		cnt_d = cnt_q;
		if (push & ~pop) begin
			cnt_d = cnt_q + {{AW{1'b0}}, 1'b1};
		end else if (pop & ~push) begin
			cnt_d = cnt_q - {{AW{1'b0}}, 1'b1};
		end
	end

	// Ready is registered so the writer never sees a combinational path through the drain.
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wr_ptr_q <= {AW{1'b0}};
			rd_ptr_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
			ready_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			ready_q <= (cnt_d != DEPTH[AW:0]);
			if (push) begin
				wr_ptr_q <= (wr_ptr_q == DEPTH[AW-1:0] - {{(AW-1){1'b0}}, 1'b1}) ?
					{AW{1'b0}} : wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
			end
			if (pop) begin
				rd_ptr_q <= (rd_ptr_q == DEPTH[AW-1:0] - {{(AW-1){1'b0}}, 1'b1}) ?
					{AW{1'b0}} : rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
			end
		end
	end

	generate
		for (i = 0; i < DEPTH; i = i + 1) begin : g_entry
			always @(posedge clk_in) begin
				if (push && (wr_ptr_q == i)) begin
					mem_q[i] <= in_data_in;
				end
			end
		end
	endgenerate
endmodule

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Capability bit 0 marks coding unsupported.
// - Capability bit 1 marks coding supported.
// - Pixel count register returns width times height.
// - Upper byte-count quadlet readable at its offset.
// - Lower byte-count quadlet readable at next offset.
// - Byte count follows dimensions and colour coding.
// - Byte count adds padding and feature data.
// - Packet limits report granularity of four bytes.
// - Packet limits report maximum of 4096 bytes.
// - Host writes packet size in first half.
// - Smaller packet size yields more packets per frame.
// - Second half reports recommended minimum packet size.
// - Recommendation refreshes on any format setting change.
// - Packets per frame follows size, coding, packet size.

module ifq_regs #(
	parameter [10:0] CODING_CAPS = `IFQ_CODING_CAPS_RST,
	parameter FIFO_DEPTH = 32,
	parameter FIFO_AW = 5
) (
	input wire sys_clk_in, // 40 MHz clock.
	input wire rstn_in, // Asynchronous reset, active low.
	input wire [`IFQ_ADDR_W-1:0] reg_addr_in, // Register byte address.
	input wire [31:0] reg_wdata_in, // Register write data.
	input wire reg_wr_in, // Write strobe.
	input wire reg_rd_in, // Read strobe.
	output reg [31:0] reg_rdata_out, // Read data, one cycle after the strobe.
	input wire [15:0] aoi_width_in, // Current image width in columns.
	input wire [15:0] aoi_height_in, // Current image height in rows.
	input wire [7:0] colour_coding_selector_in, // Current colour coding.
	input wire [31:0] feature_bytes_in, // Bytes appended by enabled features.
	input wire [31:0] pix_data_in, // Image data quadlet.
	input wire pix_valid_in, // Image data valid.
	output wire pix_ready_out, // FIFO can accept.
	output reg [31:0] pkt_data_out, // Packet data quadlet.
	output reg pkt_valid_out, // Packet data valid.
	output reg pkt_sop_out, // First quadlet of a packet.
	output reg pkt_eop_out, // Last quadlet of a packet.
	input wire pkt_ready_in, // Link accepts a quadlet.
	output reg [15:0] pkt_size_out, // Programmed packet size in bytes.
	output reg [31:0] pkt_per_frame_out, // Packets needed for one frame.
	output reg pkt_limit_over_out, // Packets per frame above the limit.
	output reg calc_busy_out // Derived values being recomputed.
);
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_DIV_REC = 3'b010;
	localparam [2:0] ST_DIV_PPF = 3'b100;

	reg rst_meta_q;
	reg rst_sync_q;
	reg [2:0] state_q;
	reg [15:0] width_q;
	reg [15:0] height_q;
	reg [7:0] coding_q;
	reg [31:0] feature_q;
	reg dirty_q;
	reg [31:0] pixels_q;
	reg [63:0] bytes_q;
	reg [15:0] rec_q;
	reg [39:0] dvd_q;
	reg [16:0] rem_q;
	reg [15:0] dvs_q;
	reg [5:0] step_q;
	reg [3:0] half_bytes;
	reg [15:0] quads_q;
	reg [15:0] pos_q;
	reg [15:0] wr_size;
	reg [31:0] rd_word;
	wire [31:0] pixels_d;
	wire [35:0] payload_half;
	wire [34:0] payload;
	wire [34:0] padded;
	wire [39:0] total_d;
	wire changed;
	wire [16:0] rem_sh;
	wire take;
	wire [39:0] quo_ceil;
	wire [39:0] rec_round;
	wire [31:0] fifo_data;
	wire fifo_valid;
	wire fifo_pop;
	wire [31:0] caps_word;
	genvar b;

	////////////////////////////////////////////////////////////////////////////////

	always @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	// Supported codings carry a one, the others a zero, bit 0 standing at the MSB.
	generate
		for (b = 0; b < 32; b = b + 1) begin : g_caps
			if (b < 11) begin : g_used
				assign caps_word[31-b] = CODING_CAPS[b];
			end else begin : g_resv
				assign caps_word[31-b] = 1'b0;
			end
		end
	endgenerate

	// Half-bytes per pixel for each colour coding; 4:1:1 needs one and a half bytes.
	always @* begin
		case (colour_coding_selector_in)
		8'h00: half_bytes = 4'h2;
		8'h01: half_bytes = 4'h3;
		8'h02: half_bytes = 4'h4;
		8'h03: half_bytes = 4'h6;
		8'h04: half_bytes = 4'h6;
		8'h05: half_bytes = 4'h4;
		8'h06: half_bytes = 4'hC;
		8'h07: half_bytes = 4'h4;
		8'h08: half_bytes = 4'hC;
		8'h09: half_bytes = 4'h2;
		8'h0A: half_bytes = 4'h4;
		default: half_bytes = 4'h2;
		endcase
	end

	assign pixels_d = aoi_width_in * aoi_height_in;
	assign payload_half = pixels_d * half_bytes;
	assign payload = payload_half[35:1] + {34'h000000000, payload_half[0]};
	assign padded = (payload + 35'h000000003) & ~35'h000000003;
	assign total_d = {5'h00, padded} + {8'h00, feature_bytes_in};

	assign changed = (aoi_width_in != width_q) | (aoi_height_in != height_q) |
		(colour_coding_selector_in != coding_q) | (feature_bytes_in != feature_q);

	assign rem_sh = {rem_q[15:0], dvd_q[39]};
	assign take = (rem_sh >= {1'b0, dvs_q});
	assign quo_ceil = dvd_q + {39'h0000000000, (rem_q != 17'h00000)};
	assign rec_round = (quo_ceil + 40'h0000000003) & ~40'h0000000003;

	// A written packet size is snapped down to the unit and held inside the legal range.
	always @* begin
		wr_size = reg_wdata_in[`IFQ_FIRST_HALF] & ~(`IFQ_PKT_UNIT - 16'h0001);
		if (wr_size < `IFQ_PKT_UNIT) begin
			wr_size = `IFQ_PKT_UNIT;
		end else if (wr_size > `IFQ_PKT_MAX) begin
			wr_size = `IFQ_PKT_MAX;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	// Two serial divisions share one subtractor: byte count by the packet limit for the
	// recommendation, then by the packet size for the packet count. It costs 82 cycles.
	always @(posedge sys_clk_in or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			state_q <= ST_IDLE;
			width_q <= 16'h0000;
			height_q <= 16'h0000;
			coding_q <= 8'h00;
			feature_q <= 32'h00000000;
			dirty_q <= 1'b1;
			pixels_q <= 32'h00000000;
			bytes_q <= 64'h0000000000000000;
			rec_q <= `IFQ_PKT_UNIT;
			dvd_q <= 40'h0000000000;
			rem_q <= 17'h00000;
			dvs_q <= 16'h0001;
			step_q <= 6'h00;
			pkt_size_out <= `IFQ_PKT_SIZE_RST;
			pkt_per_frame_out <= 32'h00000000;
			pkt_limit_over_out <= 1'b0;
			calc_busy_out <= 1'b0;
		end else begin
			if (reg_wr_in && (reg_addr_in == `IFQ_OFF_PKT_SIZE)) begin
				pkt_size_out <= wr_size;
			end
			case (state_q)
			ST_IDLE: begin
				// A write in the start cycle keeps the dirty flag, so it is not lost.
				if (changed || dirty_q || (reg_wr_in && (reg_addr_in == `IFQ_OFF_PKT_SIZE))) begin
					width_q <= aoi_width_in;
					height_q <= aoi_height_in;
					coding_q <= colour_coding_selector_in;
					feature_q <= feature_bytes_in;
					dirty_q <= reg_wr_in && (reg_addr_in == `IFQ_OFF_PKT_SIZE);
					pixels_q <= pixels_d;
					bytes_q <= {24'h000000, total_d};
					dvd_q <= total_d;
					rem_q <= 17'h00000;
					dvs_q <= `IFQ_PPF_LIMIT;
					step_q <= 6'h00;
					calc_busy_out <= 1'b1;
					state_q <= ST_DIV_REC;
				end
			end
			ST_DIV_REC, ST_DIV_PPF: begin
				if (reg_wr_in && (reg_addr_in == `IFQ_OFF_PKT_SIZE)) begin
					dirty_q <= 1'b1;
				end
				if (step_q == `IFQ_DIV_STEPS) begin
					step_q <= 6'h00;
					rem_q <= 17'h00000;
					dvd_q <= bytes_q[39:0];
					if (state_q == ST_DIV_REC) begin
						// Smallest packet size that keeps the frame within the packet limit.
						if (rec_round > {24'h000000, `IFQ_PKT_MAX}) begin
							rec_q <= `IFQ_PKT_MAX;
						end else if (rec_round < {24'h000000, `IFQ_PKT_UNIT}) begin
							rec_q <= `IFQ_PKT_UNIT;
						end else begin
							rec_q <= rec_round[15:0];
						end
						dvs_q <= pkt_size_out;
						state_q <= ST_DIV_PPF;
					end else begin
						pkt_per_frame_out <= (quo_ceil[39:32] != 8'h00) ?
							32'hFFFFFFFF : quo_ceil[31:0];
						pkt_limit_over_out <= (quo_ceil > {24'h000000, `IFQ_PPF_LIMIT});
						calc_busy_out <= 1'b0;
						state_q <= ST_IDLE;
					end
				end else begin
					rem_q <= take ? (rem_sh - {1'b0, dvs_q}) : rem_sh;
					dvd_q <= {dvd_q[38:0], take};
					step_q <= step_q + 6'h01;
				end
			end
			default: begin
				state_q <= ST_IDLE;
			end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	always @* begin
		case (reg_addr_in)
		`IFQ_OFF_CODING_CAPS: rd_word = caps_word;
		`IFQ_OFF_PIXEL_COUNT: rd_word = pixels_q;
		`IFQ_OFF_BYTES_UPPER: rd_word = bytes_q[63:32];
		`IFQ_OFF_BYTES_LOWER: rd_word = bytes_q[31:0];
		`IFQ_OFF_PKT_LIMITS: rd_word = {`IFQ_PKT_UNIT, `IFQ_PKT_MAX};
		`IFQ_OFF_PKT_SIZE: rd_word = {pkt_size_out, rec_q};
		`IFQ_OFF_PKT_PER_FRAME: rd_word = pkt_per_frame_out;
		default: rd_word = 32'h00000000;
		endcase
	end

	// Unmapped addresses and cycles without a read strobe return zero.
	always @(posedge sys_clk_in or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			reg_rdata_out <= 32'h00000000;
		end else begin
			reg_rdata_out <= reg_rd_in ? rd_word : 32'h00000000;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	ifq_fifo #(
		.W(32),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_fifo (
		.clk_in(sys_clk_in),
		.rstn_in(rst_sync_q),
		.in_data_in(pix_data_in),
		.in_valid_in(pix_valid_in),
		.in_ready_out(pix_ready_out),
		.out_data_out(fifo_data),
		.out_valid_out(fifo_valid),
		.out_ready_in(fifo_pop)
	);

	assign fifo_pop = ~pkt_valid_out | pkt_ready_in;

	// Packet boundaries follow the programmed size; a new size applies at the next packet.
	always @(posedge sys_clk_in or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			pkt_data_out <= 32'h00000000;
			pkt_valid_out <= 1'b0;
			pkt_sop_out <= 1'b0;
			pkt_eop_out <= 1'b0;
			quads_q <= 16'h0000;
			pos_q <= 16'h0000;
		end else if (fifo_pop) begin
			pkt_valid_out <= fifo_valid;
			if (fifo_valid) begin
				pkt_data_out <= fifo_data;
				pkt_sop_out <= (pos_q == 16'h0000);
				if (pos_q == 16'h0000) begin
					quads_q <= {2'b00, pkt_size_out[15:2]};
					pkt_eop_out <= (pkt_size_out[15:2] == 14'h0001);
					pos_q <= (pkt_size_out[15:2] == 14'h0001) ? 16'h0000 : 16'h0001;
				end else begin
					pkt_eop_out <= (pos_q == quads_q - 16'h0001);
					pos_q <= (pos_q == quads_q - 16'h0001) ? 16'h0000 : pos_q + 16'h0001;
				end
			end
		end
	end
endmodule

// ==== ifq_regs_bench.sv ====
// Self-checking bench of the image format query register bank.
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
module ifq_regs_bench;
	reg clk = 1'b0;
	reg rstn = 1'b0;
	reg [11:0] addr = 12'h000;
	reg [31:0] wdata = 32'h00000000;
	reg wr = 1'b0;
	reg rd = 1'b0;
	reg [15:0] wid = 16'h0008;
	reg [15:0] hgt = 16'h0004;
	reg [7:0] code = 8'h00;
	reg [31:0] feat = 32'h00000000;
	reg [31:0] pd = 32'h00000000;
	reg pv = 1'b0;
	reg [1:0] mode = 2'h0;
	reg [15:0] esz = 16'h1000;
	reg [31:0] r;
	wire [31:0] rdata, qd, ppf;
	wire [15:0] sz;
	wire pr, qv, qs, qe, rdy, lim, busy;
	integer n_fail = 0;
	integer compares = 0;
	integer cyc = 0;
	integer rx = 0;
	always #12.5 clk = ~clk;
	ifq_regs dut (.sys_clk_in(clk), .rstn_in(rstn), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .aoi_width_in(wid),
		.aoi_height_in(hgt), .colour_coding_selector_in(code), .feature_bytes_in(feat),
		.pix_data_in(pd), .pix_valid_in(pv), .pix_ready_out(pr), .pkt_data_out(qd),
		.pkt_valid_out(qv), .pkt_sop_out(qs), .pkt_eop_out(qe), .pkt_ready_in(rdy),
		.pkt_size_out(sz), .pkt_per_frame_out(ppf), .pkt_limit_over_out(lim),
		.calc_busy_out(busy));
	ifq_sink sink (.clk_in(clk), .rstn_in(rstn), .mode_in(mode), .ready_out(rdy));
	////////////////////////////////////////////////////////////////////////////////
	task chk(input string nm, input [63:0] got, input [63:0] exp);
		compares = compares + 1;
		if (got !== exp) begin
			n_fail = n_fail + 1;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task final_report;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task wreg(input [11:0] a, input [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task rreg(input [11:0] a);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		r = rdata;
	endtask
	task settle;
		integer k;
		repeat (4) @(posedge clk);
		for (k = 0; k < 400 && busy !== 1'b0; k = k + 1)
			@(posedge clk);
		chk("calc done", busy, 0);
	endtask
	// Expected values come from the width, height, coding, feature bytes and packet size the bench set.
	task check_all;
		reg [63:0] b, rec, n;
		reg [3:0] h;
		h = code == 1 ? 3 : code == 2 || code == 5 || code == 7 || code == 10 ? 4 :
			code == 3 || code == 4 ? 6 : code == 6 || code == 8 ? 12 : 2;
		b = wid;
		b = ((b * hgt * h + 1) / 2 + 3) & ~64'h3;
		b = b + feat;
		rec = ((b + 4094) / 4095 + 3) & ~64'h3;
		rec = rec < 4 ? 4 : rec > 4096 ? 4096 : rec;
		n = (b + esz - 1) / esz;
		rreg(12'h034);
		chk("pixels", r, wid * hgt);
		rreg(12'h038);
		chk("bytes upper", r, b[63:32]);
		rreg(12'h03C);
		chk("bytes lower", r, b[31:0]);
		rreg(12'h044);
		chk("size and rec", r, {esz, rec[15:0]});
		rreg(12'h048);
		chk("packets", r, n);
		chk("packets port", ppf, n);
		chk("size port", sz, esz);
		chk("over limit", lim, n > 4095);
	endtask
	task t_fixed;
		rreg(12'h040);
		chk("limits", r, 32'h00041000);
		rreg(12'h014);
		chk("caps", r, 32'h80000000);
		wreg(12'h040, 32'h00000000);
		rreg(12'h040);
		chk("limits kept", r, 32'h00041000);
		rreg(12'h100);
		chk("unmapped", r, 0);
		check_all;
		$display("t_fixed done");
	endtask
	task t_format;
		integer c;
		wid <= 16'h0005;
		hgt <= 16'h0003;
		feat <= 32'h00000008;
		// Code 11 is not a defined coding and must fall back to one byte per pixel.
		for (c = 0; c < 12; c = c + 1) begin
			code <= c[7:0];
			settle;
			check_all;
		end
		wid <= 16'hFFFF;
		hgt <= 16'hFFFF;
		code <= 8'h06;
		settle;
		check_all;
		$display("t_format done");
	endtask
	task t_size;
		reg [79:0] tbl;
		reg [15:0] v;
		integer k;
		tbl = 80'h0008_1003_0002_FFFC_0006;
		wid <= 16'h0040;
		hgt <= 16'h0040;
		code <= 8'h00;
		feat <= 32'h00000000;
		settle;
		for (k = 0; k < 5; k = k + 1) begin
			v = tbl[79 - 16 * k -: 16];
			wreg(12'h044, {v, 16'hABCD});
			v = v & 16'hFFFC;
			esz = v < 4 ? 4 : v > 4096 ? 4096 : v;
			rreg(12'h044);
			chk("size now", r[31:16], esz);
			settle;
			check_all;
		end
		$display("t_size done");
	endtask
	// The link stalls until the FIFO refuses, then drains slowly and then promptly.
	task t_stream;
		integer k, t;
		wreg(12'h044, 32'h00080000);
		esz = 16'h0008;
		settle;
		k = 0;
		pv <= 1'b1;
		for (t = 0; t < 400 && k < 48; t = t + 1) begin
			@(posedge clk);
			if (pr === 1'b1) begin
				k = k + 1;
				pd <= k;
			end
			if (t == 60) begin
				chk("fifo full", pr, 0);
				mode <= 2'h1;
			end
			if (t == 90)
				mode <= 2'h2;
		end
		pv <= 1'b0;
		for (t = 0; t < 200 && rx < 48; t = t + 1)
			@(posedge clk);
		chk("beats", rx, 48);
		$display("t_stream done");
	endtask
	always @(posedge clk) begin
		if (qv === 1'b1 && rdy === 1'b1) begin
			chk("beat data", qd, rx);
			chk("beat start", qs, rx % 2 == 0);
			chk("beat end", qe, rx % 2 == 1);
			rx = rx + 1;
		end
	end
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			n_fail = n_fail + 1;
			final_report;
		end
	end
	initial begin
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		settle;
		t_fixed;
		t_format;
		t_size;
		t_stream;
		final_report;
	end
endmodule

// ==== ifq_regs_sva.sv ====
// Port checks of the image format query register bank.
`timescale 1ns/100ps
`include "ifq_defines.vh"
////////////////////////////////////////////////////////////////////////////////
module ifq_regs_chk #(
	parameter [10:0] CODING_CAPS = `IFQ_CODING_CAPS_RST
) (
	input wire sys_clk_in, // Clock.
	input wire rstn_in, // Reset, active low.
	input wire [`IFQ_ADDR_W-1:0] reg_addr_in, // Address.
	input wire [31:0] reg_wdata_in, // Write data.
	input wire reg_wr_in, // Write strobe.
	input wire reg_rd_in, // Read strobe.
	input wire [31:0] reg_rdata_out, // Read data.
	input wire [15:0] aoi_width_in, // Width.
	input wire [15:0] aoi_height_in, // Height.
	input wire [31:0] pkt_data_out, // Packet data.
	input wire pkt_valid_out, // Packet valid.
	input wire pkt_sop_out, // Packet start.
	input wire pkt_eop_out, // Packet end.
	input wire pkt_ready_in, // Link ready.
	input wire [15:0] pkt_size_out, // Packet size.
	input wire [31:0] pkt_per_frame_out, // Packets per frame.
	input wire pkt_limit_over_out, // Over the limit.
	input wire calc_busy_out // Recomputing.
);
	wire [31:0] caps_exp;
	wire [15:0] wsz = reg_wdata_in[31:16] & 16'hFFFC;
	reg [15:0] beats_q;
	genvar i;
	assign caps_exp[20:0] = 21'h000000;
	for (i = 0; i < 11; i = i + 1) begin : g_caps
		assign caps_exp[31 - i] = CODING_CAPS[i];
	end
	// Beats taken since the last packet end, to judge packet framing.
	always @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in)
			beats_q <= 16'h0000;
		else if (pkt_valid_out && pkt_ready_in)
			beats_q <= pkt_eop_out ? 16'h0000 : beats_q + 16'h0001;
	end
	default clocking @(posedge sys_clk_in);
	endclocking
	default disable iff (!rstn_in);
	limits_read_a: assert property (
		reg_rd_in && reg_addr_in == 12'h040 |=> reg_rdata_out == 32'h00041000)
		else $error("packet limits read wrong");
	caps_read_a: assert property (
		reg_rd_in && reg_addr_in == 12'h014 |=> reg_rdata_out == caps_exp)
		else $error("coding caps read wrong");
	pixel_read_a: assert property (
		reg_rd_in && reg_addr_in == 12'h034 && !calc_busy_out && $stable(aoi_width_in)
		&& $stable(aoi_height_in) |=> reg_rdata_out == aoi_width_in * aoi_height_in)
		else $error("pixel count read wrong");
	size_write_a: assert property (
		reg_wr_in && reg_addr_in == 12'h044 && wsz != 16'h0000 && wsz <= 16'h1000
		|=> pkt_size_out == $past(wsz))
		else $error("packet size write lost");
	size_range_a: assert property (
		pkt_size_out[1:0] == 2'h0 && pkt_size_out >= 16'h0004 && pkt_size_out <= 16'h1000)
		else $error("packet size out of range");
	size_read_a: assert property (
		reg_rd_in && reg_addr_in == 12'h044 |=> reg_rdata_out[31:16] == $past(pkt_size_out))
		else $error("packet size read wrong");
	limit_flag_a: assert property (
		!calc_busy_out |-> pkt_limit_over_out == (pkt_per_frame_out > 32'h00000FFF))
		else $error("limit flag disagrees with count");
	busy_bound_a: assert property (
		$rose(calc_busy_out) |-> ##[1:300] !calc_busy_out)
		else $error("recompute never ends");
	beat_hold_a: assert property (
		pkt_valid_out && !pkt_ready_in |=> pkt_valid_out && $stable(pkt_data_out)
		&& $stable(pkt_sop_out) && $stable(pkt_eop_out))
		else $error("stalled beat changed");
	pkt_framing_a: assert property (
		pkt_valid_out && pkt_ready_in |-> pkt_sop_out == (beats_q == 16'h0000)
		&& pkt_eop_out == (beats_q + 16'h0001 == pkt_size_out >> 2))
		else $error("packet framing wrong");
endmodule

bind ifq_regs ifq_regs_chk #(.CODING_CAPS(CODING_CAPS)) u_chk (.sys_clk_in, .rstn_in,
	.reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .aoi_width_in,
	.aoi_height_in, .pkt_data_out, .pkt_valid_out, .pkt_sop_out, .pkt_eop_out,
	.pkt_ready_in, .pkt_size_out, .pkt_per_frame_out, .pkt_limit_over_out, .calc_busy_out);

// ==== ifq_sink.sv ====
// Packet link model: takes quadlets at once, every other cycle, or not at all.
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
module ifq_sink (
	input wire clk_in, // Clock.
	input wire rstn_in, // Reset, active low.
	input wire [1:0] mode_in, // 0 stall, 1 slow, 2 prompt.
	output reg ready_out // Link accepts a quadlet.
);
	reg tog_q;
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tog_q <= 1'b0;
			ready_out <= 1'b0;
		end else begin
			tog_q <= ~tog_q;
			ready_out <= mode_in[1] | (mode_in[0] & tog_q);
		end
	end
endmodule
